/* design/ctr_pkg.sv */
// Constants for the cache tag controller that drives the external tag memory.
// Assumes a 100 MHz clock; all pin timings but tag-to-hit, index-stable, drive-to-readout and write-to-low-Z are converted to cycles here.
package ctr_pkg;

    // ==========================================================
    // Geometry
    localparam int INDEX_W   = 12;
    localparam int TAG_W     = 4;

    // ==========================================================
    // Timing in ns as printed, and derived cycle counts
    localparam int CLK_NS                    = 10;
    localparam int INDEX_TO_HIT_DELAY_NS     = 20;  // Max
    localparam int TAG_TO_HIT_DELAY_NS       = 12;  // Max
    localparam int COMPARE_SETUP_NS          = 7;   // Min
    localparam int INDEX_STABLE_TO_WRITE_END_NS = 16; // Min
    localparam int WRITE_PULSE_NS            = 16;  // Min
    localparam int WRITE_TAG_SETUP_NS        = 12;  // Min
    localparam int INDEX_TO_READOUT_DELAY_NS = 20;  // Max
    localparam int DRIVE_TO_READOUT_DELAY_NS = 10;  // Max
    localparam int OE_TO_HIGHZ_NS            = 7;   // Max
    localparam int WRITE_RELEASE_DELAY_NS    = 8;   // Max
    localparam int WRITE_TO_LOWZ_NS          = 5;   // Min
    localparam int ZEROIZE_PULSE_WIDTH_NS    = 36;  // Min

    // Converts any timing, pulse or wait, to cycles: ceiling, at least one cycle
    function automatic int ns_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Answer waits cover two synchroniser stages plus one cycle of margin,
    // so the first flop samples the pin well after the worst-case access
    localparam int HIT_WAIT_CYC   = ns_cyc(INDEX_TO_HIT_DELAY_NS) + 3;
    localparam int CMP_SETUP_CYC  = ns_cyc(COMPARE_SETUP_NS);
    localparam int WRITE_LOW_CYC  = ns_cyc(WRITE_PULSE_NS);
    localparam int TAG_SETUP_CYC  = ns_cyc(WRITE_TAG_SETUP_NS);
    localparam int READ_WAIT_CYC  = ns_cyc(INDEX_TO_READOUT_DELAY_NS) + 3;
    localparam int OE_OFF_CYC     = ns_cyc(OE_TO_HIGHZ_NS);
    localparam int WE_OFF_CYC     = ns_cyc(WRITE_RELEASE_DELAY_NS);
    localparam int ZERO_LOW_CYC   = ns_cyc(ZEROIZE_PULSE_WIDTH_NS);
    localparam int CNT_W          = 4;

    // ==========================================================
    // Commands and states
    typedef enum logic [1:0] {
        CTR_CMD_COMPARE = 2'b00,
        CTR_CMD_READ    = 2'b01,
        CTR_CMD_WRITE   = 2'b10,
        CTR_CMD_CLEAR   = 2'b11
    } ctr_cmd_e;

    typedef enum logic [2:0] {
        CTR_ST_IDLE    = 3'b000,
        CTR_ST_COMPARE = 3'b001,
        CTR_ST_READ    = 3'b010,
        CTR_ST_WRITE   = 3'b011,
        CTR_ST_CLEAR   = 3'b100,
        CTR_ST_RECOVER = 3'b101
    } ctr_state_e;

endpackage

/* design/ctr_sync.sv */
// Two-flop synchroniser for pins arriving from the tag memory.
// Assumes one clock; inputs are asynchronous device outputs.
`timescale 1ns/1ps
module ctr_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_in,
    input  wire logic         nrst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;

    // ==========================================================
    // Capture stage; only the second stage is read downstream
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule

/* design/ctr_host.sv */
// Host controller for an asynchronous cache tag memory.
// Assumes a single 100 MHz clock; the memory pins are asynchronous.
`timescale 1ns/1ps
module ctr_host
    import ctr_pkg::*;
(
    input  wire logic                        mclk_in,
    input  wire logic                        nrst_in,
    input  wire logic                        req_valid_in,
    input  wire ctr_pkg::ctr_cmd_e           req_cmd_in,
    input  wire logic [ctr_pkg::INDEX_W-1:0] req_index_in,
    input  wire logic [ctr_pkg::TAG_W-1:0]   req_tag_in,
    output logic                             req_ready_out,
    output logic                             done_out,
    output logic                             hit_out,
    output logic [ctr_pkg::TAG_W-1:0]        rd_tag_out,
    output logic [ctr_pkg::INDEX_W-1:0]      tag_index_out,
    output logic                             write_en_n_out,
    output logic                             out_en_n_out,
    output logic                             array_zeroize_n_out,
    output logic [ctr_pkg::TAG_W-1:0]        tag_data_o_out,
    output logic                             tag_data_oe_out,
    input  wire logic [ctr_pkg::TAG_W-1:0]   tag_data_i_in,
    input  wire logic                        match_in
);
    import ctr_pkg::*;

    ctr_state_e             state_ff;
    logic [CNT_W-1:0]       cnt_ff;
    logic [TAG_W-1:0]       data_sync;
    logic                   match_sync;
    ctr_cmd_e               cmd_ff;

    // ==========================================================
    // Pins from the memory pass two flops before use
    ctr_sync #(.W(TAG_W + 1)) u_sync (
        .mclk_in  (mclk_in),
        .nrst_in  (nrst_in),
        .async_in ({tag_data_i_in, match_in}),
        .sync_out ({data_sync, match_sync})
    );

    // ==========================================================
    // Sequencer: one memory cycle per accepted request
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            state_ff <= CTR_ST_IDLE;
            cnt_ff   <= '0;
            cmd_ff   <= CTR_CMD_COMPARE;
        end else begin
            case (state_ff)
                CTR_ST_IDLE: begin
                    if (req_valid_in) begin
                        cmd_ff <= req_cmd_in;
                        case (req_cmd_in)
                            CTR_CMD_COMPARE: begin
                                state_ff <= CTR_ST_COMPARE;
                                cnt_ff   <= CNT_W'(HIT_WAIT_CYC);
                            end
                            CTR_CMD_READ: begin
                                state_ff <= CTR_ST_READ;
                                cnt_ff   <= CNT_W'(READ_WAIT_CYC);
                            end
                            CTR_CMD_WRITE: begin
                                state_ff <= CTR_ST_WRITE;
                                cnt_ff   <= CNT_W'(WRITE_LOW_CYC);
                            end
                            default: begin
                                state_ff <= CTR_ST_CLEAR;
                                cnt_ff   <= CNT_W'(ZERO_LOW_CYC);
                            end
                        endcase
                    end
                end
                CTR_ST_COMPARE, CTR_ST_READ, CTR_ST_WRITE, CTR_ST_CLEAR: begin
                    if (cnt_ff > CNT_W'(1)) begin
                        cnt_ff <= cnt_ff - CNT_W'(1);
                    end else begin
                        state_ff <= CTR_ST_RECOVER;
                        // Bus turnaround before the next cycle may drive again
                        cnt_ff   <= CNT_W'(OE_OFF_CYC + WE_OFF_CYC);
                    end
                end
                CTR_ST_RECOVER: begin
                    if (cnt_ff > CNT_W'(1)) begin
                        cnt_ff <= cnt_ff - CNT_W'(1);
                    end else begin
                        state_ff <= CTR_ST_IDLE;
                    end
                end
                default: state_ff <= CTR_ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Pin drive, registered; index held stable for whole cycle
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            tag_index_out       <= '0;
            write_en_n_out      <= 1'b1;
            out_en_n_out        <= 1'b1;
            array_zeroize_n_out <= 1'b1;
            tag_data_o_out      <= '0;
            tag_data_oe_out     <= 1'b0;
        end else if (state_ff == CTR_ST_IDLE && req_valid_in) begin
            tag_index_out       <= req_index_in;
            tag_data_o_out      <= req_tag_in;
            // Compare: both enables high ahead of sampling
            write_en_n_out      <= (req_cmd_in != CTR_CMD_WRITE);
            out_en_n_out        <= (req_cmd_in != CTR_CMD_READ);
            array_zeroize_n_out <= (req_cmd_in != CTR_CMD_CLEAR);
            // Host drives data only for compare and write, never while OE low
            tag_data_oe_out     <= (req_cmd_in == CTR_CMD_COMPARE) ||
                                   (req_cmd_in == CTR_CMD_WRITE);
        end else if (state_ff != CTR_ST_IDLE && cnt_ff == CNT_W'(1) &&
                     state_ff != CTR_ST_RECOVER) begin
            // End of cycle: release strobes, data held one more edge (zero hold)
            write_en_n_out      <= 1'b1;
            out_en_n_out        <= 1'b1;
            array_zeroize_n_out <= 1'b1;
        end else if (state_ff == CTR_ST_RECOVER) begin
            tag_data_oe_out     <= 1'b0;
        end
    end

    // ==========================================================
    // Result capture at the end of the wait; hit only sampled on compare
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            done_out   <= 1'b0;
            hit_out    <= 1'b0;
            rd_tag_out <= '0;
        end else begin
            done_out <= 1'b0;
            if (cnt_ff == CNT_W'(1) && state_ff != CTR_ST_IDLE &&
                state_ff != CTR_ST_RECOVER) begin
                done_out <= 1'b1;
                if (state_ff == CTR_ST_COMPARE) begin
                    hit_out <= match_sync;
                end
                if (state_ff == CTR_ST_READ) begin
                    rd_tag_out <= data_sync;
                end
            end
        end
    end

    // Ready only in idle; hit ignored during write and clear
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            req_ready_out <= 1'b0;
        end else begin
            req_ready_out <= (state_ff == CTR_ST_RECOVER && cnt_ff == CNT_W'(1)) ||
                             (state_ff == CTR_ST_IDLE && !req_valid_in);
        end
    end

    // ==========================================================
    // Checks
    chk_write_low_width: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $fell(write_en_n_out) |-> !write_en_n_out [*2])
        else $error("write enable low too short");
    chk_clear_low_width: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $fell(array_zeroize_n_out) |-> !array_zeroize_n_out [*4])
        else $error("zeroize pulse too short");
    chk_index_stable_write: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !write_en_n_out && $past(!write_en_n_out) |-> $stable(tag_index_out))
        else $error("index moved during write");
    chk_no_drive_read: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !out_en_n_out |-> !tag_data_oe_out)
        else $error("host drives data while memory reads out");
    chk_write_data_setup: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $rose(write_en_n_out) |-> $past(tag_data_oe_out, 2))
        else $error("write data not set up");
    chk_compare_wait: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (state_ff == CTR_ST_IDLE && req_valid_in && req_cmd_in == CTR_CMD_COMPARE)
        |=> (!done_out) [*5] ##1 done_out)
        else $error("compare result timing wrong");
    // Read result only after the access time plus both synchroniser stages
    chk_read_wait: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (state_ff == CTR_ST_IDLE && req_valid_in && req_cmd_in == CTR_CMD_READ)
        |=> (!done_out) [*5] ##1 done_out)
        else $error("read result timing wrong");
    chk_one_strobe_low: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !(!write_en_n_out && !out_en_n_out))
        else $error("write and read strobes both low");
    chk_clear_alone: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !array_zeroize_n_out |-> write_en_n_out && out_en_n_out && !tag_data_oe_out)
        else $error("pins active during clear");

    cov_compare: cover property (@(posedge mclk_in) done_out && hit_out);
    cov_write:   cover property (@(posedge mclk_in) $rose(write_en_n_out));
    cov_read:    cover property (@(posedge mclk_in) $rose(out_en_n_out));
    cov_clear:   cover property (@(posedge mclk_in) $rose(array_zeroize_n_out));

endmodule

/* tb/ctr_tag_mem_model.sv */
// Behavioural model of the asynchronous 4K x 4 tag memory with comparator.
// Assumes the bench resolves the shared data lines and feeds them back.
`timescale 1ns/1ps
module ctr_tag_mem_model
    import ctr_pkg::*;
(
    input  wire logic               slow_in,
    input  wire logic [INDEX_W-1:0] tag_index_in,
    input  wire logic               write_en_n_in,
    input  wire logic               out_en_n_in,
    input  wire logic               array_zeroize_n_in,
    input  wire logic [TAG_W-1:0]   bus_in,
    output logic      [TAG_W-1:0]   dq_out,
    output logic                    dq_oe_out,
    output logic                    match_out
);
    // ==========================================================
    // Storage, preset to a known pattern
    logic [TAG_W-1:0] mem [0:4095];
    int               gen;
    int               dly;

    initial begin
        gen = 0;
        match_out = 1'b0;
        dq_oe_out = 1'b0;
        dq_out = 4'h0;
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 4'h5;
        end
    end

    // Slow answers (18 ns) stay inside the 20 ns limit but exceed the 12 ns one
    always_comb dly = slow_in ? 18 : 4;

    // Clear wins over everything
    always @(negedge array_zeroize_n_in) begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 4'h0;
        end
        gen++;
    end

    // Data captured as the strobe rises, zero hold
    always @(posedge write_en_n_in) begin
        if (array_zeroize_n_in === 1'b1) begin
            mem[tag_index_in] = bus_in;
            gen++;
        end
    end

    // Old result held 3 ns, then garbage until settled; invalid modes mislead
    always @(tag_index_in, bus_in, write_en_n_in, out_en_n_in, array_zeroize_n_in, gen) begin
        logic cmp;
        logic rd;
        cmp = write_en_n_in & out_en_n_in & array_zeroize_n_in;
        rd = write_en_n_in & ~out_en_n_in & array_zeroize_n_in;
        match_out <= #3 ~match_out;
        match_out <= #(dly) cmp ~^ (mem[tag_index_in] == bus_in);
        dq_oe_out <= #(rd ? 3 : 1) rd;
        dq_out <= #(dly) rd ? mem[tag_index_in] : ~dq_out;
    end
endmodule

/* tb/ctr_host_tb.sv */
// Self-checking bench for the tag memory host controller.
// Assumes the behavioural memory model on the far side of the pins.
`timescale 1ns/1ps
module ctr_host_tb;
    import ctr_pkg::*;
    logic                 mclk_in, nrst_in, req_valid_in, slow, req_ready_out, done_out;
    logic                 hit_out, write_en_n_out, out_en_n_out, array_zeroize_n_out;
    logic                 tag_data_oe_out, match_in, dq_oe;
    ctr_cmd_e             req_cmd_in;
    logic [INDEX_W-1:0]   req_index_in, tag_index_out;
    logic [TAG_W-1:0]     req_tag_in, rd_tag_out, tag_data_o_out, tag_data_i_in, dq;
    int                   err_count, samples_checked;

    // Host drive has priority; otherwise the model's lines
    assign tag_data_i_in = tag_data_oe_out ? tag_data_o_out : dq;

    ctr_host ctr_host_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .req_valid_in(req_valid_in),
        .req_cmd_in(req_cmd_in), .req_index_in(req_index_in), .req_tag_in(req_tag_in),
        .req_ready_out(req_ready_out), .done_out(done_out), .hit_out(hit_out),
        .rd_tag_out(rd_tag_out), .tag_index_out(tag_index_out), .write_en_n_out(write_en_n_out),
        .out_en_n_out(out_en_n_out), .array_zeroize_n_out(array_zeroize_n_out),
        .tag_data_o_out(tag_data_o_out), .tag_data_oe_out(tag_data_oe_out),
        .tag_data_i_in(tag_data_i_in), .match_in(match_in));
    ctr_tag_mem_model ctr_tag_mem_model_i (.slow_in(slow), .tag_index_in(tag_index_out),
        .write_en_n_in(write_en_n_out), .out_en_n_in(out_en_n_out),
        .array_zeroize_n_in(array_zeroize_n_out), .bus_in(tag_data_i_in), .dq_out(dq),
        .dq_oe_out(dq_oe), .match_out(match_in));

    // ==========================================================
    // Clock and bus contention watch
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        if (nrst_in === 1'b1 && tag_data_oe_out === 1'b1 && dq_oe === 1'b1) begin
            err_count++;
            $display("unexpected at %0t: both ends drive the data lines", $time);
        end
    end

    task automatic finish_test();
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    // One request, waits bounded, watches the pins on every edge until done
    task automatic do_req(input ctr_cmd_e cmd, input logic [11:0] idx, input logic [3:0] tag);
        int n;
        int lo;
        int setup;
        n = 0;
        lo = 0;
        setup = 0;
        while (req_ready_out !== 1'b1 && n < 20) begin
            @(posedge mclk_in);
            n++;
        end
        req_valid_in <= 1'b1;
        req_cmd_in <= cmd;
        req_index_in <= idx;
        req_tag_in <= tag;
        @(posedge mclk_in);
        req_valid_in <= 1'b0;
        while (done_out !== 1'b1 && n < 40) begin
            @(posedge mclk_in);
            n++;
            if (write_en_n_out === 1'b0) begin
                lo++;
                check(tag_index_out === idx && tag_data_oe_out === 1'b1
                      && tag_data_o_out === tag, "write pins moved");
            end
            if (array_zeroize_n_out === 1'b0) lo++;
            // Setup only counts once the new index and tag stand on the pins
            if ({write_en_n_out, out_en_n_out, array_zeroize_n_out} === 3'b111 &&
                tag_index_out === idx && tag_data_o_out === tag) setup++;
        end
        if (n >= 40) begin
            err_count++;
            $display("unexpected at %0t: no completion", $time);
            finish_test();
        end else begin
            if (cmd == CTR_CMD_WRITE) check(lo >= WRITE_LOW_CYC, "write strobe short");
            if (cmd == CTR_CMD_CLEAR) check(lo >= ZERO_LOW_CYC, "clear strobe short");
            if (cmd == CTR_CMD_COMPARE) check(setup >= CMP_SETUP_CYC, "compare setup");
            @(posedge mclk_in);
            check(done_out === 1'b0, "done longer than one cycle");
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic sc_write_compare();
        do_req(CTR_CMD_WRITE, 12'hfff, 4'ha);
        do_req(CTR_CMD_COMPARE, 12'hfff, 4'ha);
        check(hit_out === 1'b1, "no hit on equal tag");
        for (int b = 0; b < 4; b++) begin
            do_req(CTR_CMD_COMPARE, 12'hfff, 4'ha ^ (4'h1 << b));
            check(hit_out === 1'b0, "hit on one-bit difference");
        end
    endtask

    task automatic sc_read();
        do_req(CTR_CMD_WRITE, 12'h000, 4'h3);
        do_req(CTR_CMD_COMPARE, 12'hfff, 4'ha);
        do_req(CTR_CMD_READ, 12'h000, 4'h0);
        check(rd_tag_out === 4'h3, "read data");
        check(hit_out === 1'b1, "read disturbed hit");
    endtask

    task automatic sc_clear_slow();
        do_req(CTR_CMD_CLEAR, 12'h123, 4'hf);
        do_req(CTR_CMD_READ, 12'hfff, 4'h0);
        check(rd_tag_out === 4'h0, "clear left data");
        slow <= 1'b1;
        do_req(CTR_CMD_WRITE, 12'h800, 4'hf);
        do_req(CTR_CMD_COMPARE, 12'h800, 4'hf);
        check(hit_out === 1'b1, "slow compare missed");
        do_req(CTR_CMD_READ, 12'h800, 4'h0);
        check(rd_tag_out === 4'hf, "slow read data");
    endtask

    // Reset in mid-run: outputs return to idle, stored tags survive
    task automatic sc_reset_mid();
        @(posedge mclk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        check(hit_out === 1'b0 && done_out === 1'b0 && req_ready_out === 1'b0 &&
              tag_data_oe_out === 1'b0, "reset outputs");
        check({write_en_n_out, out_en_n_out, array_zeroize_n_out} === 3'b111,
              "reset strobes mid-run");
        nrst_in <= 1'b1;
        do_req(CTR_CMD_COMPARE, 12'h800, 4'hf);
        check(hit_out === 1'b1, "compare after reset missed");
    endtask

    initial begin
        nrst_in = 1'b0;
        req_valid_in = 1'b0;
        req_cmd_in = CTR_CMD_COMPARE;
        req_index_in = '0;
        req_tag_in = '0;
        slow = 1'b0;
        err_count = 0;
        samples_checked = 0;
        repeat (8) @(posedge mclk_in);
        check({write_en_n_out, out_en_n_out, array_zeroize_n_out} === 3'b111, "reset strobes");
        nrst_in <= 1'b1;
        sc_write_compare();
        sc_read();
        sc_clear_slow();
        sc_reset_mid();
        finish_test();
    end
endmodule
